// file: hw/ppc_pkg.sv
// package: constants and types for the programmable pad cell logic
package ppc_pkg;

	// conditioner choices
	typedef enum logic [1:0] {
		PPC_COND_FLOAT = 2'h0,
		PPC_COND_PULLUP = 2'h1,
		PPC_COND_PULLDOWN = 2'h2,
		PPC_COND_KEEPER = 2'h3
	} ppc_cond_t;

	// tie-off choices for output data and output enable
	typedef enum logic [1:0] {
		PPC_TIE_NONE = 2'h0,
		PPC_TIE_LOW = 2'h1,
		PPC_TIE_HIGH = 2'h2
	} ppc_tie_t;

	// drive strength
	localparam logic PPC_DRIVE_LOW = 1'h0;
	localparam logic PPC_DRIVE_HIGH = 1'h1;

	// defaults before configuration
	localparam logic PPC_HYST_DEFAULT = 1'h1;
	localparam ppc_cond_t PPC_COND_DEFAULT = PPC_COND_PULLUP;

	// phases of the cell's life
	typedef enum logic [2:0] {
		PPC_PH_UNCONF = 3'h1,
		PPC_PH_INIT = 3'h2,
		PPC_PH_RUN = 3'h4
	} ppc_phase_t;

	// storage element indices
	localparam int PPC_EL_IN = 0;
	localparam int PPC_EL_OUT = 1;
	localparam int PPC_EL_OE = 2;
	localparam int PPC_NUM_EL = 3;

endpackage : ppc_pkg

// file: hw/ppc_store_if.sv
// interface: shared storage-element controls between pad top and storage module
`timescale 1ns/1ps
`default_nettype none
interface ppc_store_if;
	import ppc_pkg::*;
	logic load;
	logic [PPC_NUM_EL-1:0] init_val;
	logic [PPC_NUM_EL-1:0] use_ce;
	logic [PPC_NUM_EL-1:0] clk_inv;
	logic in_latch;
	logic ce;
	logic [PPC_NUM_EL-1:0] d;
	logic [PPC_NUM_EL-1:0] q;
	modport ctrl (output load, init_val, use_ce, clk_inv, in_latch, ce, d, input q);
	modport store (input load, init_val, use_ce, clk_inv, in_latch, ce, d, output q);
endinterface : ppc_store_if
`default_nettype wire

// file: hw/ppc_store.sv
// storage elements of the pad cell: input ff/latch, output ff, output-enable ff
`timescale 1ns/1ps
`default_nettype none
module ppc_store (
	input wire logic clk, // system clock
	input wire logic resetn, // async reset, active low
	input wire logic user_clk, // shared pad clock, sampled
	ppc_store_if.store sif // storage controls and data
);
	import ppc_pkg::*;

	// ----------------------------------------
	// clock edge and level per element
	// ----------------------------------------
	logic user_clk_q;
	logic [PPC_NUM_EL-1:0] q_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			user_clk_q <= 1'h0;
		end else begin
			user_clk_q <= user_clk;
		end
	end

	// pad clock is a sampled level, so its edges are detected on clk; no second domain
	genvar g;
	generate
		for (g = 0; g < PPC_NUM_EL; g++) begin : g_el
			logic lvl;
			logic lvl_prev;
			logic rise;
			logic en;
			assign lvl = user_clk ^ sif.clk_inv[g]; // see R18
			assign lvl_prev = user_clk_q ^ sif.clk_inv[g];
			assign rise = lvl & ~lvl_prev;
			assign en = ~sif.use_ce[g] | sif.ce; // see R17
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					q_q[g] <= 1'h0;
				end else if (sif.load) begin
					q_q[g] <= sif.init_val[g]; // see R20
				end else if (en) begin
					if (g == PPC_EL_IN && sif.in_latch) begin
						if (!lvl) begin
							q_q[g] <= sif.d[g]; // see R19
						end
					end else if (rise) begin
						q_q[g] <= sif.d[g]; // see R01
					end
				end
			end
		end
	endgenerate

	assign sif.q = q_q;

endmodule : ppc_store
`default_nettype wire

// file: hw/ppc_pad.sv
// top: configurable logic of one programmable pad cell
`timescale 1ns/1ps
`default_nettype none
// Function
// R01 - pin offered inward directly and through a flip-flop or latch
// R02 - output optionally inverted, then direct or through an output flip-flop
// R03 - effective enable low floats the driver, high drives the value
// R04 - output and enable polarity per pad, each tieable high or low
// R05 - user holds data low and toggles enable for open drain
// R06 - drive strength low or high, low by default
// R07 - conditioner choice: pull-up, pull-down or keeper
// R08 - pull-up active on every pad during initialization
// R09 - unused pads keep pull-up after initialization
// R10 - power-down set by control bit, pad handling gated by select bit
// R11 - low-power output pad floated for whole power-down
// R12 - low-power pad conditioner becomes keeper during power-down
// R13 - low-power input optionally forced low during power-down
// R14 - before configuration: hysteresis on, low drive, pull-up
// R15 - before configuration pins operate through boundary-scan
// R16 - unused configured pads are inputs with pull-up
// R17 - storage elements share clock and enable; disabled ones hold
// R18 - clock polarity selectable per storage element
// R19 - input latch transparent while clock low; only input may latch
// R20 - storage elements loaded with initial values during configuration
// R21 - configuration settings are static during operation
module ppc_pad (
	input wire logic clk, // system clock
	input wire logic resetn, // async reset, active low
	input wire logic cfg_start, // starts initialization
	input wire logic cfg_done, // configuration complete
	input wire logic pad_used, // design uses this pad
	input wire logic pin_i, // pin level as seen on the pad
	output logic pin_o, // value to drive on the pin
	output logic pin_oe_n, // pin output enable, low = drive
	output logic drive_high, // high drive strength selected
	output logic hyst_en, // input hysteresis enabled
	output logic pull_up_en, // pull-up on
	output logic pull_down_en, // pull-down on
	output logic keeper_en, // keeper on
	output logic keep_level, // level held by the keeper
	input wire logic scan_mode, // boundary-scan owns the pin while unconfigured
	input wire logic scan_o, // boundary-scan drive value
	input wire logic scan_oe, // boundary-scan drive enable, high = drive
	output logic scan_i, // pin level to boundary-scan
	input wire logic user_clk, // shared storage clock from user logic
	input wire logic user_ce, // shared clock enable from user logic
	input wire logic user_o, // output data from user logic
	input wire logic user_oe, // output enable from user logic, high = drive
	output logic in_direct, // pin value bypassing the input storage element
	output logic registered_input_value, // registered pin value
	input wire logic cfg_in_latch, // input element as latch
	input wire logic [2:0] cfg_clk_inv, // per element clock inversion
	input wire logic [2:0] cfg_use_ce, // per element enable gating
	input wire logic [2:0] cfg_init, // per element initial value
	input wire logic cfg_out_inv, // invert output data
	input wire logic cfg_oe_inv, // invert output enable
	input wire ppc_pkg::ppc_tie_t cfg_out_tie, // output data tie-off
	input wire ppc_pkg::ppc_tie_t cfg_oe_tie, // output enable tie-off
	input wire logic cfg_out_reg, // output through output flip-flop
	input wire logic cfg_oe_reg, // enable through enable flip-flop
	input wire logic cfg_drive_high, // high drive strength
	input wire logic cfg_hyst, // hysteresis enable
	input wire ppc_pkg::ppc_cond_t cfg_cond, // conditioner choice
	input wire logic cfg_lp_en, // pad enabled for low-power
	input wire logic cfg_lp_in_low, // force input low in power-down
	input wire logic power_down_request_bit, // power control register bit
	input wire logic power_down_select_pad // pad select bit of power-down select register
);
	import ppc_pkg::*;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	// pin, scan and user clock come from outside the clock domain
	logic pin_s1_q, pin_s2_q;
	logic uclk_s1_q, uclk_s2_q;
	logic so_s1_q, so_s2_q, soe_s1_q, soe_s2_q;
	logic sm_s1_q, sm_s2_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pin_s1_q <= 1'h1;
			pin_s2_q <= 1'h1;
			uclk_s1_q <= 1'h0;
			uclk_s2_q <= 1'h0;
			so_s1_q <= 1'h0;
			so_s2_q <= 1'h0;
			soe_s1_q <= 1'h0;
			soe_s2_q <= 1'h0;
			sm_s1_q <= 1'h0;
			sm_s2_q <= 1'h0;
		end else begin
			pin_s1_q <= pin_i;
			pin_s2_q <= pin_s1_q;
			uclk_s1_q <= user_clk;
			uclk_s2_q <= uclk_s1_q;
			so_s1_q <= scan_o;
			so_s2_q <= so_s1_q;
			soe_s1_q <= scan_oe;
			soe_s2_q <= soe_s1_q;
			sm_s1_q <= scan_mode;
			sm_s2_q <= sm_s1_q;
		end
	end

	// ----------------------------------------
	// phase tracking
	// ----------------------------------------
	ppc_phase_t phase_q, phase_d;

	always_comb begin
		phase_d = phase_q;
		case (phase_q)
			PPC_PH_UNCONF: begin
				if (cfg_start) begin
					phase_d = PPC_PH_INIT;
				end
			end
			PPC_PH_INIT: begin
				if (cfg_done) begin
					phase_d = PPC_PH_RUN;
				end
			end
			PPC_PH_RUN: begin
				if (cfg_start) begin
					phase_d = PPC_PH_INIT;
				end
			end
			default: begin
				phase_d = PPC_PH_UNCONF;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			phase_q <= PPC_PH_UNCONF;
		end else begin
			phase_q <= phase_d;
		end
	end

	logic running;
	logic active;
	logic pwd;
	assign running = (phase_q == PPC_PH_RUN);
	assign active = running && pad_used; // see R16
	// configuration is static in operation, so it is read without resampling
	assign pwd = power_down_request_bit && power_down_select_pad && cfg_lp_en; // see R10 R21

	// ----------------------------------------
	// storage elements
	// ----------------------------------------
	ppc_store_if sif ();
	logic out_src;
	logic oe_src;

	function automatic logic ppc_tie(input ppc_tie_t tie, input logic v);
		case (tie)
			PPC_TIE_LOW: ppc_tie = 1'h0;
			PPC_TIE_HIGH: ppc_tie = 1'h1;
			default: ppc_tie = v;
		endcase
	endfunction

	assign out_src = ppc_tie(cfg_out_tie, user_o ^ cfg_out_inv); // see R02 R04
	assign oe_src = ppc_tie(cfg_oe_tie, user_oe ^ cfg_oe_inv); // see R04

	assign sif.load = (phase_q == PPC_PH_INIT); // see R20
	assign sif.init_val = cfg_init;
	assign sif.use_ce = cfg_use_ce;
	assign sif.clk_inv = cfg_clk_inv;
	assign sif.in_latch = cfg_in_latch;
	assign sif.ce = user_ce;
	assign sif.d = {oe_src, out_src, pin_s2_q};

	ppc_store u_store (
		.clk(clk),
		.resetn(resetn),
		.user_clk(uclk_s2_q),
		.sif(sif)
	);

	logic out_eff;
	logic oe_eff;
	assign out_eff = cfg_out_reg ? sif.q[PPC_EL_OUT] : out_src; // see R02
	assign oe_eff = cfg_oe_reg ? sif.q[PPC_EL_OE] : oe_src;

	// ----------------------------------------
	// pad drive and conditioner
	// ----------------------------------------
	logic drive_d;
	logic val_d;
	ppc_cond_t cond_d;

	always_comb begin
		if (!running) begin
			// unconfigured: scan owns the pin; initializing: pin floats; pull-up on in both
			drive_d = (phase_q == PPC_PH_UNCONF) && sm_s2_q && soe_s2_q; // see R15
			val_d = so_s2_q;
			cond_d = PPC_COND_DEFAULT; // see R08 R14
		end else if (!active) begin
			drive_d = 1'h0; // see R16
			val_d = 1'h0;
			cond_d = PPC_COND_PULLUP; // see R09
		end else if (pwd) begin
			drive_d = 1'h0; // see R11
			val_d = out_eff;
			cond_d = PPC_COND_KEEPER; // see R12
		end else begin
			// R05 open drain needs nothing here: user holds data low
			drive_d = oe_eff; // see R03
			val_d = out_eff;
			cond_d = cfg_cond; // see R07
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pin_oe_n <= 1'h1;
			pin_o <= 1'h0;
		end else begin
			pin_oe_n <= ~drive_d;
			pin_o <= val_d;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pull_up_en <= 1'h1;
			pull_down_en <= 1'h0;
			keeper_en <= 1'h0;
			drive_high <= PPC_DRIVE_LOW;
			hyst_en <= PPC_HYST_DEFAULT;
		end else begin
			pull_up_en <= (cond_d == PPC_COND_PULLUP);
			pull_down_en <= (cond_d == PPC_COND_PULLDOWN);
			keeper_en <= (cond_d == PPC_COND_KEEPER); // see R07
			drive_high <= running ? cfg_drive_high : PPC_DRIVE_LOW; // see R06 R14
			hyst_en <= running ? cfg_hyst : PPC_HYST_DEFAULT; // see R14
		end
	end

	// keeper holds the level the pin had when the keeper turned on, whether driven by us or outside
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			keep_level <= 1'h1;
		end else if (!keeper_en || cond_d != PPC_COND_KEEPER) begin
			keep_level <= pin_s2_q; // see R12
		end
	end

	// ----------------------------------------
	// inward values
	// ----------------------------------------
	logic force_low;
	assign force_low = pwd && cfg_lp_in_low; // see R13

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			in_direct <= 1'h1;
			registered_input_value <= 1'h0;
			scan_i <= 1'h1;
		end else begin
			in_direct <= force_low ? 1'h0 : pin_s2_q; // see R01
			registered_input_value <= force_low ? 1'h0 : sif.q[PPC_EL_IN];
			scan_i <= pin_s2_q;
		end
	end

endmodule : ppc_pad
`default_nettype wire

// file: bench/ppc_pad_assertions.sv
// checker: pad cell behaviour seen at the top ports
`timescale 1ns/1ps
`default_nettype none
module ppc_pad_assertions (
	input wire logic clk, // clock
	input wire logic resetn, // reset
	input wire logic cfg_start, // init
	input wire logic cfg_done, // configured
	input wire logic pad_used, // used
	input wire logic pin_oe_n, // drive when low
	input wire logic drive_high, // strength
	input wire logic hyst_en, // hysteresis
	input wire logic pull_up_en, // pull-up
	input wire logic pull_down_en, // pull-down
	input wire logic keeper_en, // keeper
	input wire logic scan_mode, // scan owns pin
	input wire logic scan_oe, // scan enable
	input wire logic in_direct, // direct input
	input wire logic cfg_lp_en, // low-power pad
	input wire logic cfg_lp_in_low, // force low
	input wire logic power_down_request_bit, // power-down
	input wire logic power_down_select_pad // pad select
);
	logic unconf_q;
	logic run_q;
	logic lp_sleep;
	assign lp_sleep = power_down_request_bit && power_down_select_pad && cfg_lp_en;
	// phase followed from the strobes, so a pulsed configured strobe is judged right
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			unconf_q <= 1'h1;
			run_q <= 1'h0;
		end else begin
			unconf_q <= unconf_q && !cfg_start;
			run_q <= run_q ? !cfg_start : (!unconf_q && cfg_done);
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// --------------------------------
	// conditioner and phases
	// --------------------------------
	a_cond_one_hot: assert property ($onehot0({pull_up_en, pull_down_en, keeper_en}))
		else $error("several conditioners on");
	a_unconf_defaults: assert property (unconf_q[*2] |-> pull_up_en && hyst_en && !drive_high)
		else $error("unconfigured defaults lost");
	a_scan_drives_pin: assert property ((unconf_q && scan_mode && scan_oe)[*5] |-> !pin_oe_n)
		else $error("scan drive not on pin");
	a_init_pull_up: assert property ((!unconf_q && !run_q)[*2] |-> pull_up_en && pin_oe_n)
		else $error("pad not pulled up in init");
	a_unused_pull_up: assert property ((run_q && !pad_used && !lp_sleep)[*3] |-> pull_up_en && pin_oe_n)
		else $error("unused pad not an input with pull-up");
	// --------------------------------
	// power-down
	// --------------------------------
	a_sleep_pin_float: assert property ((run_q && lp_sleep)[*2] |-> pin_oe_n)
		else $error("pad driven in power-down");
	a_sleep_keeper_on: assert property ((run_q && pad_used && lp_sleep)[*2] |-> keeper_en)
		else $error("keeper off in power-down");
	a_sleep_input_low: assert property ((run_q && lp_sleep && cfg_lp_in_low)[*4] |-> !in_direct)
		else $error("input not forced low");
endmodule // ppc_pad_assertions
bind ppc_pad ppc_pad_assertions u_chk (
	.clk(clk),
	.resetn(resetn),
	.cfg_start(cfg_start),
	.cfg_done(cfg_done),
	.pad_used(pad_used),
	.pin_oe_n(pin_oe_n),
	.drive_high(drive_high),
	.hyst_en(hyst_en),
	.pull_up_en(pull_up_en),
	.pull_down_en(pull_down_en),
	.keeper_en(keeper_en),
	.scan_mode(scan_mode),
	.scan_oe(scan_oe),
	.in_direct(in_direct),
	.cfg_lp_en(cfg_lp_en),
	.cfg_lp_in_low(cfg_lp_in_low),
	.power_down_request_bit(power_down_request_bit),
	.power_down_select_pad(power_down_select_pad)
);
`default_nettype wire

// file: bench/ppc_pin_model.sv
// partner model: board pin with pad driver, conditioner and a board driver
`timescale 1ns/1ps
`default_nettype none
module ppc_pin_model (
	input wire logic clk, // clock
	input wire logic pin_o, // pad value
	input wire logic pin_oe_n, // pad drives when low
	input wire logic pull_up_en, // pull-up
	input wire logic pull_down_en, // pull-down
	input wire logic keeper_en, // keeper
	input wire logic keep_level, // keeper level
	input wire logic ext_oe, // board driver on
	input wire logic ext_val, // board value
	output logic pin_i // pin level
);
	logic flt_q = 1'h0;
	// a floating pin must not settle to a tidy value
	always_ff @(posedge clk) flt_q <= ~flt_q;
	always_comb begin
		if (!pin_oe_n) pin_i = pin_o;
		else if (ext_oe) pin_i = ext_val;
		else if (pull_up_en) pin_i = 1'h1;
		else if (pull_down_en) pin_i = 1'h0;
		else if (keeper_en) pin_i = keep_level;
		else pin_i = flt_q;
	end
endmodule // ppc_pin_model
`default_nettype wire

// file: bench/ppc_pad_tb.sv
// testbench: directed pad cell scenarios against the pin model
`timescale 1ns/1ps
`default_nettype none
module ppc_pad_tb;
	import ppc_pkg::*;
	logic clk = 1'h0, resetn = 1'h0, cfg_start = 1'h0, cfg_done = 1'h0, pad_used = 1'h1, pin_i;
	logic scan_mode = 1'h0, scan_o = 1'h0, scan_oe = 1'h0, user_clk = 1'h0, user_ce = 1'h0;
	logic user_o = 1'h0, user_oe = 1'h0, cfg_in_latch = 1'h0, cfg_out_inv = 1'h0, cfg_oe_inv = 1'h0;
	logic cfg_out_reg = 1'h0, cfg_oe_reg = 1'h0, cfg_drive_high = 1'h0, cfg_hyst = 1'h1;
	logic cfg_lp_en = 1'h0, cfg_lp_in_low = 1'h0, power_down_request_bit = 1'h0;
	logic power_down_select_pad = 1'h0, ext_oe = 1'h0, ext_val = 1'h0;
	logic [2:0] cfg_clk_inv = 3'h0, cfg_use_ce = 3'h0, cfg_init = 3'h1;
	ppc_tie_t cfg_out_tie = PPC_TIE_NONE, cfg_oe_tie = PPC_TIE_NONE;
	ppc_cond_t cfg_cond = PPC_COND_PULLUP;
	logic pin_o, pin_oe_n, drive_high, hyst_en, pull_up_en, pull_down_en, keeper_en, keep_level;
	logic scan_i, in_direct, registered_input_value;
	int miscompares = 0, compares = 0, cycles = 0;
	ppc_pad DUT (.*);
	ppc_pin_model u_pin (.*);
	// --------------------------------
	// helpers
	// --------------------------------
	task chk(input logic s, input logic e);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch at %0t: got %b want %b", $time, s, e);
		end
	endtask
	task w(input int n);
		repeat (n) @(negedge clk);
	endtask
	task uclk(input logic v);
		user_clk = v;
		w(6);
	endtask
	task wrap_up;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			$display("mismatch at %0t: timeout", $time);
			wrap_up();
		end
	end
	// --------------------------------
	// scenarios
	// --------------------------------
	initial begin
		w(4);
		resetn = 1'h1;
		w(8);
		chk(pin_oe_n, 1'h1);
		chk(hyst_en, 1'h1);
		chk(in_direct, 1'h1);
		chk(pull_up_en, 1'h1);
		chk(drive_high, 1'h0);
		scan_mode = 1'h1;
		scan_oe = 1'h1;
		w(8);
		chk(scan_i, 1'h0);
		scan_o = 1'h1;
		w(8);
		chk(scan_i, 1'h1);
		scan_mode = 1'h0;
		scan_oe = 1'h0;
		$display("test unconfigured done");
		user_oe = 1'h1;
		user_o = 1'h1;
		cfg_start = 1'h1;
		w(3);
		chk(pin_oe_n, 1'h1);
		chk(registered_input_value, 1'h1);
		cfg_start = 1'h0;
		cfg_done = 1'h1;
		w(3);
		chk(pin_oe_n, 1'h0);
		chk(drive_high, 1'h0);
		cfg_drive_high = 1'h1;
		w(3);
		chk(drive_high, 1'h1);
		cfg_oe_tie = PPC_TIE_HIGH;
		for (int i = 0; i < 6; i++) begin
			cfg_out_tie = ppc_tie_t'(i % 3);
			cfg_out_inv = (i > 2);
			w(3);
			chk(pin_o, (i % 3 == 0) ? (i < 3) : (i % 3 == 2));
		end
		cfg_out_tie = PPC_TIE_NONE;
		cfg_out_inv = 1'h0;
		for (int i = 0; i < 6; i++) begin
			cfg_oe_tie = ppc_tie_t'(i % 3);
			cfg_oe_inv = (i > 2);
			w(3);
			chk(pin_oe_n, (i % 3 == 0) ? (i > 2) : (i % 3 == 1));
		end
		cfg_oe_tie = PPC_TIE_NONE;
		cfg_oe_inv = 1'h0;
		user_o = 1'h0;
		w(6);
		chk(in_direct, 1'h0);
		user_oe = 1'h0;
		w(6);
		chk(in_direct, 1'h1);
		$display("test output path done");
		cfg_cond = PPC_COND_PULLDOWN;
		w(6);
		chk(in_direct, 1'h0);
		cfg_cond = PPC_COND_KEEPER;
		w(6);
		chk(in_direct, 1'h0);
		chk(keeper_en, 1'h1);
		cfg_cond = PPC_COND_PULLUP;
		w(6);
		cfg_cond = PPC_COND_KEEPER;
		w(6);
		chk(in_direct, 1'h1);
		chk(keep_level, 1'h1);
		cfg_cond = PPC_COND_FLOAT;
		w(3);
		chk(pull_up_en | pull_down_en | keeper_en, 1'h0);
		cfg_cond = PPC_COND_PULLUP;
		pad_used = 1'h0;
		user_oe = 1'h1;
		w(3);
		chk(pin_oe_n, 1'h1);
		pad_used = 1'h1;
		user_oe = 1'h0;
		ext_oe = 1'h1;
		uclk(1'h1);
		chk(registered_input_value, 1'h0);
		uclk(1'h0);
		cfg_use_ce = 3'h1;
		ext_val = 1'h1;
		uclk(1'h1);
		chk(registered_input_value, 1'h0);
		uclk(1'h0);
		user_ce = 1'h1;
		uclk(1'h1);
		chk(registered_input_value, 1'h1);
		cfg_clk_inv = 3'h1;
		ext_val = 1'h0;
		uclk(1'h0);
		chk(registered_input_value, 1'h0);
		ext_val = 1'h1;
		uclk(1'h1);
		chk(registered_input_value, 1'h0);
		cfg_clk_inv = 3'h0;
		uclk(1'h0);
		cfg_in_latch = 1'h1;
		ext_val = 1'h1;
		w(6);
		chk(registered_input_value, 1'h1);
		uclk(1'h1);
		ext_val = 1'h0;
		w(6);
		chk(registered_input_value, 1'h1);
		uclk(1'h0);
		cfg_in_latch = 1'h0;
		ext_oe = 1'h0;
		$display("test input path done");
		cfg_out_reg = 1'h1;
		user_oe = 1'h1;
		user_o = 1'h1;
		w(6);
		chk(pin_o, 1'h0);
		uclk(1'h1);
		chk(pin_o, 1'h1);
		cfg_out_reg = 1'h0;
		cfg_oe_reg = 1'h1;
		user_oe = 1'h0;
		w(3);
		chk(pin_oe_n, 1'h0);
		uclk(1'h0);
		uclk(1'h1);
		chk(pin_oe_n, 1'h1);
		cfg_oe_reg = 1'h0;
		user_oe = 1'h1;
		cfg_cond = PPC_COND_PULLDOWN;
		cfg_lp_en = 1'h1;
		power_down_request_bit = 1'h1;
		w(6);
		chk(pin_oe_n, 1'h0);
		chk(pull_down_en, 1'h1);
		power_down_request_bit = 1'h0;
		power_down_select_pad = 1'h1;
		w(2);
		power_down_request_bit = 1'h1;
		w(6);
		chk(pin_oe_n, 1'h1);
		chk(in_direct, 1'h1);
		cfg_lp_in_low = 1'h1;
		w(6);
		chk(in_direct, 1'h0);
		chk(registered_input_value, 1'h0);
		power_down_request_bit = 1'h0;
		w(3);
		chk(pin_oe_n, 1'h0);
		$display("test power-down done");
		wrap_up();
	end
endmodule // ppc_pad_tb
`default_nettype wire
